/* File: verilog/sssp_pkg.sv */
// Package with the register map, field layout and types of the spread-spectrum sequencer.
`default_nettype none
package sssp_pkg;
  // Register offsets on the serial programming port.
  localparam logic [7:0] STEP_AND_COUNT_ADDR   = 8'h60;
  localparam logic [7:0] DITHER_AND_OFFSET_ADDR = 8'h61;
  localparam logic [7:0] DELTA_PAIR_0_ADDR     = 8'h62;
  // Reset values.
  localparam logic [7:0] STEP_AND_COUNT_RST    = 8'h00;
  localparam logic [7:0] DITHER_AND_OFFSET_RST = 8'h00;
  localparam logic [7:0] DELTA_PAIR_0_RST      = 8'h00;
  // Field positions.
  localparam int STEP_PERIOD_LSB   = 4;
  localparam int SAMPLE_COUNT_LSB  = 0;
  localparam int DITHER_BIT        = 7;
  localparam int DOUBLE_BIT        = 6;
  localparam int FIRST_SAMPLE_LSB  = 0;
  localparam int DELTA_HI_LSB      = 4;
  localparam int DELTA_LO_LSB      = 0;
  // Widths and table size.
  localparam int NIBBLE_W     = 4;
  localparam int OFFSET_W     = 6;
  localparam int FRAC_W       = 10;
  localparam int STORED_DELTAS = 2;
  // Dither generator seed; the taps are set in the sequencer.
  localparam logic [6:0] LFSR_SEED = 7'h01;

  typedef struct packed {
    logic [3:0] step_period;
    logic [3:0] sample_count;
    logic       dither_en;
    logic       double_flag;
    logic [5:0] first_sample;
  } sssp_cfg_t;

  typedef enum logic [0:0] {
    SSSP_IDLE,
    SSSP_RUN
  } sssp_state_t;
endpackage
`default_nettype wire

/* File: verilog/sssp_sequencer.sv */
// Spread-spectrum modulation sequencer for the first PLL fractional feedback divider.
//
// Notes on behaviour
// [RULE_01] Hold each sample for step-period compare cycles.
// [RULE_02] Step period zero turns modulation off.
// [RULE_03] Use only sample-count entries of the table.
// [RULE_04] First-sample field is the unsigned starting offset.
// [RULE_05] Dither enable toggles LSB dithering of fraction.
// [RULE_06] Deltas unsigned, added cumulatively after first sample.
// [RULE_07] After the last sample, restart from offset.
`timescale 1ns/10ps
`default_nettype none
module sssp_sequencer (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_sys_rst,
  // Register write and read port of the serial programming interface
  input  wire logic              i_reg_wr,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // Phase-detector comparison tick, one cycle per comparison
  input  wire logic              i_phase_compare,
  // Fractional divider outputs
  output logic [sssp_pkg::FRAC_W-1:0] o_fraction,
  output logic                   o_fraction_double_flag,
  output logic                   o_spread_active,
  output logic [3:0]             o_sample_index
);

  logic [7:0] spread_step_and_count;
  logic [7:0] spread_dither_and_offset;
  logic [7:0] spread_delta_pair_0;

  sssp_pkg::sssp_cfg_t  cfg;
  sssp_pkg::sssp_state_t state;
  sssp_pkg::sssp_state_t next_state;

  logic [3:0]                  hold_cnt;
  logic [3:0]                  next_hold_cnt;
  logic [3:0]                  sample_idx;
  logic [3:0]                  next_sample_idx;
  logic [sssp_pkg::FRAC_W-1:0] wave;
  logic [sssp_pkg::FRAC_W-1:0] next_wave;
  logic [6:0]                  lfsr;

  // Address decode, shared by the write strobes and the read selection.
  // A write to an unmapped address matches no strobe and is dropped silently.
  wire hit_step  = (i_reg_addr == sssp_pkg::STEP_AND_COUNT_ADDR);
  wire hit_dith  = (i_reg_addr == sssp_pkg::DITHER_AND_OFFSET_ADDR);
  wire hit_delta = (i_reg_addr == sssp_pkg::DELTA_PAIR_0_ADDR);
  wire wr_step   = i_reg_wr & hit_step;
  wire wr_dith   = i_reg_wr & hit_dith;
  wire wr_delta  = i_reg_wr & hit_delta;

  // Register writes. Back-to-back writes are taken on every clock.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spread_step_and_count    <= sssp_pkg::STEP_AND_COUNT_RST;
      spread_dither_and_offset <= sssp_pkg::DITHER_AND_OFFSET_RST;
      spread_delta_pair_0      <= sssp_pkg::DELTA_PAIR_0_RST;
    end else begin
      if (wr_step) begin
        spread_step_and_count <= i_reg_wdata;
      end
      if (wr_dith) begin
        spread_dither_and_offset <= i_reg_wdata;
      end
      if (wr_delta) begin
        spread_delta_pair_0 <= i_reg_wdata;
      end
    end
  end

  // Registered read data; unmapped addresses read as zero.
  // The read follows the address with one clock of latency, so a host that
  // reads straight after a write sees the new value on the next clock.
  wire [7:0] read_mux =
    hit_step  ? spread_step_and_count :
    hit_dith  ? spread_dither_and_offset :
    hit_delta ? spread_delta_pair_0 : 8'h00;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= read_mux;
    end
  end

  assign cfg.step_period  = spread_step_and_count[sssp_pkg::STEP_PERIOD_LSB +: sssp_pkg::NIBBLE_W];
  assign cfg.sample_count = spread_step_and_count[sssp_pkg::SAMPLE_COUNT_LSB +: sssp_pkg::NIBBLE_W];
  assign cfg.dither_en    = spread_dither_and_offset[sssp_pkg::DITHER_BIT];
  assign cfg.double_flag  = spread_dither_and_offset[sssp_pkg::DOUBLE_BIT];
  assign cfg.first_sample = spread_dither_and_offset[sssp_pkg::FIRST_SAMPLE_LSB +: sssp_pkg::OFFSET_W];

  // Only two deltas are stored here; entries past them add nothing.
  function automatic logic [3:0] delta_at(input logic [3:0] idx, input logic [7:0] pair);
    logic [3:0] d;
    d = 4'h0;
    if (idx == 4'h0) begin
      d = pair[sssp_pkg::DELTA_LO_LSB +: sssp_pkg::NIBBLE_W];
    end else if (idx == 4'h1) begin
      d = pair[sssp_pkg::DELTA_HI_LSB +: sssp_pkg::NIBBLE_W];
    end
    return d;
  endfunction

  wire                         spread_on  = (cfg.step_period != 4'h0); // see [RULE_02]
  wire [sssp_pkg::FRAC_W-1:0]  start_val  = {{(sssp_pkg::FRAC_W-sssp_pkg::OFFSET_W){1'b0}}, cfg.first_sample}; // see [RULE_04]
  wire                         step_done  = i_phase_compare && (hold_cnt == cfg.step_period - 4'h1); // see [RULE_01]
  wire                         last_entry = (sample_idx + 4'h1 >= cfg.sample_count); // see [RULE_03]
  wire [3:0]                   cur_delta  = delta_at(sample_idx, spread_delta_pair_0);

  // Sequencer. Settings are not shadowed: a write while running takes effect
  // at once, which may cut the current step short. Turning the step period
  // to zero drops straight back to the offset, and turning it on again costs
  // one idle clock in which the offset is loaded.
  always_comb begin
    next_state      = state;
    next_hold_cnt   = hold_cnt;
    next_sample_idx = sample_idx;
    next_wave       = wave;
    case (state)
      sssp_pkg::SSSP_IDLE: begin
        next_hold_cnt   = 4'h0;
        next_sample_idx = 4'h0;
        next_wave       = start_val;
        if (spread_on) begin
          next_state = sssp_pkg::SSSP_RUN;
        end
      end
      sssp_pkg::SSSP_RUN: begin
        if (!spread_on) begin
          next_state      = sssp_pkg::SSSP_IDLE; // see [RULE_02]
          next_hold_cnt   = 4'h0;
          next_sample_idx = 4'h0;
          next_wave       = start_val;
        end else if (step_done) begin
          next_hold_cnt = 4'h0;
          if (last_entry) begin
            next_sample_idx = 4'h0; // see [RULE_07]
            next_wave       = start_val;
          end else begin
            next_sample_idx = sample_idx + 4'h1;
            next_wave       = wave + {{(sssp_pkg::FRAC_W-sssp_pkg::NIBBLE_W){1'b0}}, cur_delta}; // see [RULE_06]
          end
        end else if (i_phase_compare) begin
          next_hold_cnt = hold_cnt + 4'h1; // see [RULE_01]
        end
      end
      default: begin
        next_state = sssp_pkg::SSSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state      <= sssp_pkg::SSSP_IDLE;
      hold_cnt   <= 4'h0;
      sample_idx <= 4'h0;
      wave       <= '0;
    end else begin
      state      <= next_state;
      hold_cnt   <= next_hold_cnt;
      sample_idx <= next_sample_idx;
      wave       <= next_wave;
    end
  end

  // A short LFSR, stepped once per comparison, supplies the dither bit.
  // It is cheap and its spectrum is good enough to break up idle tones.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lfsr <= sssp_pkg::LFSR_SEED;
    end else if (i_phase_compare) begin
      lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
    end
  end

  wire dither_bit = cfg.dither_en & lfsr[0]; // see [RULE_05]

  // The fraction, active and index outputs are loaded from the next-state values, so they move on the same
  // edge as the sequencer, one clock after the cause. Dither also applies
  // while modulation is off; the divider then sees a dithered offset.
  wire [sssp_pkg::FRAC_W-1:0] next_fraction = {next_wave[sssp_pkg::FRAC_W-1:1], next_wave[0] ^ dither_bit};

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fraction <= '0;
    end else begin
      o_fraction <= next_fraction; // see [RULE_05]
    end
  end

  // The doubling flag is only passed to the divider; it does no arithmetic here.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fraction_double_flag <= 1'b0;
    end else begin
      o_fraction_double_flag <= cfg.double_flag;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_spread_active <= 1'b0;
    end else begin
      o_spread_active <= (next_state == sssp_pkg::SSSP_RUN); // see [RULE_02]
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sample_index <= 4'h0;
    end else begin
      o_sample_index <= next_sample_idx; // see [RULE_03]
    end
  end

endmodule // sssp_sequencer
`default_nettype wire

/* File: bench/sssp_seq_props.sv */
// Checker of the sequencer port behaviour.
`timescale 1ns/10ps
`default_nettype none
module sssp_seq_props (
  // Watched ports
  input wire logic                        i_ref_clk,
  input wire logic                        i_sys_rst,
  input wire logic                        i_reg_wr,
  input wire logic [7:0]                  i_reg_addr,
  input wire logic [7:0]                  i_reg_wdata,
  input wire logic [7:0]                  o_reg_rdata,
  input wire logic                        i_phase_compare,
  input wire logic [sssp_pkg::FRAC_W-1:0] o_fraction,
  input wire logic                        o_spread_active,
  input wire logic [3:0]                  o_sample_index
);
  logic [7:0] r_step;
  logic [7:0] r_dith;
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r_step <= 8'h00;
      r_dith <= 8'h00;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 8'h60) r_step <= i_reg_wdata;
      if (i_reg_addr == 8'h61) r_dith <= i_reg_wdata;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_steady;
    o_spread_active && $past(o_spread_active) && !$past(i_reg_wr) && !i_reg_wr && !i_phase_compare && !r_dith[7];
  endsequence
  property p_rd_step; i_reg_addr == 8'h60 |=> o_reg_rdata == $past(r_step); endproperty
  property p_rd_unmapped; !(i_reg_addr inside {[8'h60:8'h62]}) |=> o_reg_rdata == 8'h00; endproperty
  property p_idle_off; r_step[7:4] == 4'h0 |=> !o_spread_active; endproperty
  property p_idle_frac; r_step[7:4] == 4'h0 && !r_dith[7] |=> o_fraction == {4'h0, $past(r_dith[5:0])}; endproperty
  property p_hold; s_steady |=> $stable(o_fraction) && $stable(o_sample_index); endproperty
  property p_count; o_spread_active |-> o_sample_index < r_step[3:0] || o_sample_index == 4'h0; endproperty
  property p_wrap;
    o_spread_active && $changed(o_sample_index) && o_sample_index == 4'h0 && !r_dith[7]
      |-> o_fraction == {4'h0, r_dith[5:0]};
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read data differs from step register");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_idle_off: assert property (p_idle_off) else $error("active with zero step period");
  a_idle_frac: assert property (p_idle_frac) else $error("idle fraction not offset");
  a_hold: assert property (p_hold) else $error("sample moved without compare pulse");
  a_count: assert property (p_count) else $error("index beyond sample count");
  a_wrap: assert property (p_wrap) else $error("wrap did not restart at offset");
endmodule // sssp_seq_props
bind sssp_sequencer sssp_seq_props sssp_seq_props_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_phase_compare(i_phase_compare), .o_fraction(o_fraction), .o_spread_active(o_spread_active),
  .o_sample_index(o_sample_index));
`default_nettype wire

/* File: bench/sssp_divider_model.sv */
// Feedback divider model that issues phase-compare pulses at a chosen spacing.
`timescale 1ns/10ps
`default_nettype none
module sssp_divider_model (
  // Clock, enable and spacing
  input  wire logic       i_ref_clk,
  input  wire logic       i_run,
  input  wire logic [3:0] i_gap,
  // Comparison pulse
  output var  logic       o_phase_compare
);
  logic [3:0] cnt = 4'h0;
  initial o_phase_compare = 1'b0;
  always @(negedge i_ref_clk) begin
    cnt = (cnt >= i_gap) ? 4'h0 : cnt + 4'h1;
    o_phase_compare = i_run && cnt == 4'h0;
  end
endmodule // sssp_divider_model
`default_nettype wire

/* File: bench/spread_spectrum_sequencer_pll0_tb_top.sv */
// Self-checking bench of the sequencer.
`timescale 1ns/10ps
`default_nettype none
module spread_spectrum_sequencer_pll0_tb_top;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, run = 1'b0, pc, dbl, act;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd;
  logic [3:0] gap = 4'h0, idx;
  logic [9:0] frac;
  int miscompares = 0, checks_done = 0, ones;
  logic [7:0] rows [4][3] = '{'{8'h60, 8'h03, 8'h03}, '{8'h61, 8'h45, 8'h45}, '{8'h62, 8'h23, 8'h23},
                              '{8'h70, 8'h5a, 8'h00}};
  sssp_sequencer sssp_sequencer_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wd), .o_reg_rdata(rd), .i_phase_compare(pc), .o_fraction(frac),
    .o_fraction_double_flag(dbl), .o_spread_active(act), .o_sample_index(idx));
  sssp_divider_model sssp_divider_model_i (.i_ref_clk(clk), .i_run(run), .i_gap(gap), .o_phase_compare(pc));
  initial forever #10 clk = ~clk;
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      while (pc !== 1'b1) @(posedge clk);
    end
    @(negedge clk);
  endtask
  task automatic walk(input logic [3:0] g);
    logic [9:0] e;
    gap = g;
    e = 10'h005;
    wreg(8'h60, 8'h23);
    repeat (2) @(negedge clk);
    run = 1'b1;
    for (int s = 0; s < 4; s++) begin
      check(frac, e);
      check(10'(idx), 10'(s % 3));
      pulses(2);
      e = (s == 2) ? 10'h005 : e + ((s == 0) ? 10'h003 : 10'h002);
    end
    run = 1'b0;
    wreg(8'h60, 8'h03);
    @(negedge clk);
    check(10'(act), 10'h0);
    check(frac, 10'h005);
    $display("walk with gap %0d done", g);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      wreg(rows[i][0], rows[i][1]);
      @(negedge clk);
      check(10'(rd), 10'(rows[i][2]));
    end
    check(10'(dbl), 10'h1);
    $display("register rows done");
    walk(4'h0);
    walk(4'h5);
    wreg(8'h61, 8'h85);
    wreg(8'h60, 8'h10);
    run = 1'b1;
    ones = 0;
    repeat (8) begin
      pulses(1);
      ones += frac[0];
    end
    check(10'(ones != 0 && ones != 8), 10'h1);
    check(10'(frac[9:1]), 10'h002);
    $display("dither done");
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    addr = 8'h61;
    @(negedge clk);
    check(10'(rd), 10'h000);
    check(frac, 10'h000);
    $display("reset done");
    stop_test();
  end
endmodule // spread_spectrum_sequencer_pll0_tb_top
`default_nettype wire
